// [pkg/cmpirq_regs.svh]
// Register offsets, field positions and reset values of the comparator event block
`ifndef CMPIRQ_REGS_SVH
`define CMPIRQ_REGS_SVH
// Printed offset 0x97 is not a multiple of four: kept as index, byte address = 4*index
`define CMPIRQ_CTRL_IDX 8'h97
`define CMPIRQ_CTRL_ADDR 12'h25c
`define CMPIRQ_IRQ_STAT_ADDR 12'h260
`define CMPIRQ_IRQ_EN_ADDR 12'h264
`define CMPIRQ_IRQ_CLR_ADDR 12'h268
`define CMPIRQ_PWR_ADDR 12'h26c
`define CMPIRQ_RAW_ADDR 12'h270
`define CMPIRQ_IDLE_RUN_BIT 5
`define CMPIRQ_FLAG_BIT 4
`define CMPIRQ_ENABLE_BIT 3
`define CMPIRQ_MODE_MSB 2
`define CMPIRQ_MODE_LSB 0
`define CMPIRQ_IE_CMP_BIT 6
`define CMPIRQ_CTRL_RESET 8'h00
`define CMPIRQ_IE_RESET 8'h00
`define CMPIRQ_IRQ_EN_RESET 2'h0
`define CMPIRQ_OVF_WAIT 2'h2
`endif

// [pkg/cmpirq_pkg.sv]
// Types shared by the comparator event block
`default_nettype none
package cmpirq_pkg;
  typedef enum logic [2:0] {
    CMPIRQ_LOW_LEVEL = 3'h0,
    CMPIRQ_RISE = 3'h1,
    CMPIRQ_DB_TOGGLE = 3'h2,
    CMPIRQ_DB_RISE = 3'h3,
    CMPIRQ_FALL = 3'h4,
    CMPIRQ_TOGGLE = 3'h5,
    CMPIRQ_DB_FALL = 3'h6,
    CMPIRQ_HIGH_LEVEL = 3'h7
  } cmpirq_mode_t;
  typedef enum logic [1:0] {
    CMPIRQ_ST_IDLE = 2'h0,
    CMPIRQ_ST_WAIT = 2'h1,
    CMPIRQ_ST_CHECK = 2'h2
  } cmpirq_db_state_t;
endpackage
`default_nettype wire

// [pkg/cmpirq_evt_if.sv]
// Event path between the detector and the register file
`timescale 1ns/100ps
`default_nettype none
interface cmpirq_evt_if;
  logic active;
  logic sample;
  logic [2:0] mode;
  logic ovf;
  logic event_hit;
  modport det (input active, input sample, input mode, input ovf, output event_hit);
  modport ctl (output active, output sample, output mode, output ovf, input event_hit);
endinterface
`default_nettype wire

// [hdl/cmpirq_debounce.sv]
// Debounce engine: waits two timer overflows then resamples
`timescale 1ns/100ps
`default_nettype none
`include "cmpirq_regs.svh"
module cmpirq_debounce (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Control
  input wire logic active,
  input wire logic start,
  input wire logic expected,
  input wire logic sample,
  input wire logic ovf,
  // Result
  output logic hit
);
  cmpirq_pkg::cmpirq_db_state_t state_r;
  logic [1:0] ovf_cnt_r;
  logic expect_r;

  // New transitions while waiting are ignored: the first one owns the window
  always_ff @(posedge clock)
  begin
    if (!rst_n || !active)
    begin
      state_r <= cmpirq_pkg::CMPIRQ_ST_IDLE;
      ovf_cnt_r <= 2'h0;
      expect_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        cmpirq_pkg::CMPIRQ_ST_IDLE:
        begin
          ovf_cnt_r <= 2'h0;
          if (start)
          begin
            state_r <= cmpirq_pkg::CMPIRQ_ST_WAIT;
            expect_r <= expected;
          end
        end
        cmpirq_pkg::CMPIRQ_ST_WAIT:
        begin
          if (ovf)
          begin
            ovf_cnt_r <= ovf_cnt_r + 2'h1;
            if (ovf_cnt_r + 2'h1 == `CMPIRQ_OVF_WAIT)
            begin
              state_r <= cmpirq_pkg::CMPIRQ_ST_CHECK;
            end
          end
        end
        cmpirq_pkg::CMPIRQ_ST_CHECK:
        begin
          state_r <= cmpirq_pkg::CMPIRQ_ST_IDLE;
        end
        default:
        begin
          state_r <= cmpirq_pkg::CMPIRQ_ST_IDLE;
        end
      endcase
    end
  end

  // Fresh sample must match the post-transition level
  assign hit = (state_r == cmpirq_pkg::CMPIRQ_ST_CHECK) && (sample == expect_r);
endmodule
`default_nettype wire

// [hdl/cmpirq_detect.sv]
// Condition detector for all eight event modes
`timescale 1ns/100ps
`default_nettype none
module cmpirq_detect (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Event path
  cmpirq_evt_if.det evt
);
  logic prev_r;
  logic rise;
  logic fall;
  logic db_start;
  logic db_hit;
  logic direct_hit;

  function automatic logic is_debounced(input logic [2:0] m);
    is_debounced = (m == cmpirq_pkg::CMPIRQ_DB_TOGGLE) || (m == cmpirq_pkg::CMPIRQ_DB_RISE)
      || (m == cmpirq_pkg::CMPIRQ_DB_FALL);
  endfunction

  // Previous sample, held low while inactive so enabling with a high output reads as a rise
  always_ff @(posedge clock)
  begin
    if (!rst_n || !evt.active)
      prev_r <= 1'b0;
    else
      prev_r <= evt.sample;
  end

  assign rise = evt.active && evt.sample && !prev_r;
  assign fall = evt.active && !evt.sample && prev_r;

  always_comb
  begin
    case (evt.mode)
      cmpirq_pkg::CMPIRQ_LOW_LEVEL: direct_hit = evt.active && !evt.sample;
      cmpirq_pkg::CMPIRQ_HIGH_LEVEL: direct_hit = evt.active && evt.sample;
      cmpirq_pkg::CMPIRQ_RISE: direct_hit = rise;
      cmpirq_pkg::CMPIRQ_FALL: direct_hit = fall;
      cmpirq_pkg::CMPIRQ_TOGGLE: direct_hit = rise || fall;
      default: direct_hit = 1'b0;
    endcase
  end

  // Only transitions matching the chosen direction start a debounce
  always_comb
  begin
    case (evt.mode)
      cmpirq_pkg::CMPIRQ_DB_TOGGLE: db_start = rise || fall;
      cmpirq_pkg::CMPIRQ_DB_RISE: db_start = rise;
      cmpirq_pkg::CMPIRQ_DB_FALL: db_start = fall;
      default: db_start = 1'b0;
    endcase
  end

  cmpirq_debounce u_debounce (
    .clock(clock),
    .rst_n(rst_n),
    .active(evt.active && is_debounced(evt.mode)),
    .start(db_start),
    .expected(evt.sample),
    .sample(evt.sample),
    .ovf(evt.ovf),
    .hit(db_hit)
  );

  assign evt.event_hit = direct_hit || db_hit;
endmodule
`default_nettype wire

// [hdl/cmpirq_top.sv]
// Comparator event block with AXI4-Lite register slave and interrupt
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "cmpirq_regs.svh"
// How it works
// - Enable bit turns comparator processing on
// - Comparator output sampled every clock
// - Debounce timing uses timer one overflows
// - Resample after two counted overflows
// - Flag only if resample matches expected level
// - Debounced flag between one and two periods
// - Idle stops logic unless idle-run set
// - Idle-run plus enabled interrupt wakes processor
// - Power-down always disables the comparator
// - Flag set on condition; software clears it
// - Interrupt gated by enable register bit six; cmp_irq is also raised by irq_stat_r & irq_en_r without it
// - Cleared enable forces output low, blocks flag
// - Mode codes: eight levels, edges, toggles
// - Control bits 5..0, reset zero, 7..6 unused
module cmpirq_top (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Analog side and timer
  input wire logic cmp_out,
  input wire logic timer1_ovf,
  input wire logic idle_mode,
  input wire logic power_down,
  // AXI4-Lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt, wake and comparator level
  output logic cmp_irq,
  output logic cmp_wake,
  output logic cmp_level
);
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  cmpirq_evt_if evt ();

  logic idle_run_bit_r;
  logic compare_event_flag_r;
  logic comparator_enable_bit_r;
  logic [2:0] event_condition_select_r;
  logic [7:0] interrupt_enable_register_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_en_r;
  logic [11:0] awaddr_r;
  logic aw_held_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_held_r;
  logic cmp_active;
  logic wr_go;
  logic wr_ctrl;
  logic wr_pwr;
  logic wr_en;
  logic wr_clr;
  logic [7:0] ctrl_view;

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ref_addr);
    addr_is = (a[11:2] == ref_addr[11:2]);
  endfunction

  function automatic logic addr_known(input logic [11:0] a);
    addr_known = addr_is(a, `CMPIRQ_CTRL_ADDR) || addr_is(a, `CMPIRQ_IRQ_STAT_ADDR)
      || addr_is(a, `CMPIRQ_IRQ_EN_ADDR) || addr_is(a, `CMPIRQ_IRQ_CLR_ADDR)
      || addr_is(a, `CMPIRQ_PWR_ADDR) || addr_is(a, `CMPIRQ_RAW_ADDR);
  endfunction

  // Idle gating and power-down override everything else
  assign cmp_active = comparator_enable_bit_r
    && !power_down
    && (!idle_mode || idle_run_bit_r);

  assign evt.active = cmp_active;
  assign evt.sample = cmp_out && cmp_active;
  assign evt.mode = event_condition_select_r;
  assign evt.ovf = timer1_ovf;

  cmpirq_detect u_detect (
    .clock(clock),
    .rst_n(rst_n),
    .evt(evt)
  );

  // Write channel capture: address and data may come in either order
  assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_ctrl = wr_go && addr_is(awaddr_r, `CMPIRQ_CTRL_ADDR) && wstrb_r[0];
  assign wr_pwr = wr_go && addr_is(awaddr_r, `CMPIRQ_PWR_ADDR) && wstrb_r[0];
  assign wr_en = wr_go && addr_is(awaddr_r, `CMPIRQ_IRQ_EN_ADDR) && wstrb_r[0];
  assign wr_clr = wr_go && addr_is(awaddr_r, `CMPIRQ_IRQ_CLR_ADDR) && wstrb_r[0];

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      aw_held_r <= 1'b0;
      awaddr_r <= 12'h000;
      s_axi_awready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      else if (wr_go)
        aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_wready <= !w_held_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      else if (wr_go)
        w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= addr_known(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Control fields; reset value all zero
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      idle_run_bit_r <= 1'(`CMPIRQ_CTRL_RESET >> `CMPIRQ_IDLE_RUN_BIT);
      comparator_enable_bit_r <= 1'(`CMPIRQ_CTRL_RESET >> `CMPIRQ_ENABLE_BIT);
      event_condition_select_r <= 3'(`CMPIRQ_CTRL_RESET >> `CMPIRQ_MODE_LSB);
    end
    else if (wr_ctrl)
    begin
      idle_run_bit_r <= wdata_r[`CMPIRQ_IDLE_RUN_BIT];
      comparator_enable_bit_r <= wdata_r[`CMPIRQ_ENABLE_BIT];
      event_condition_select_r <= wdata_r[`CMPIRQ_MODE_MSB:`CMPIRQ_MODE_LSB];
    end
  end

  // Software can only clear the flag; a same-cycle hit wins over the clear
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      compare_event_flag_r <= 1'(`CMPIRQ_CTRL_RESET >> `CMPIRQ_FLAG_BIT);
    else if (evt.event_hit && comparator_enable_bit_r)
      compare_event_flag_r <= 1'b1;
    else if (wr_ctrl && !wdata_r[`CMPIRQ_FLAG_BIT])
      compare_event_flag_r <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      interrupt_enable_register_r <= `CMPIRQ_IE_RESET;
    else if (wr_pwr)
      interrupt_enable_register_r <= wdata_r[7:0];
  end

  // Sticky status: bit0 every enabled event hit, bit1 wake from idle; set wins over clear
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      irq_stat_r <= 2'h0;
    else
      irq_stat_r <= (irq_stat_r & ~(wr_clr ? wdata_r[1:0] : 2'h0))
        | {cmp_wake, evt.event_hit && comparator_enable_bit_r};
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      irq_en_r <= `CMPIRQ_IRQ_EN_RESET;
    else if (wr_en)
      irq_en_r <= wdata_r[1:0];
  end

  // Outputs registered; flag request gated by enable register bit six
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cmp_irq <= 1'b0;
      cmp_wake <= 1'b0;
      cmp_level <= 1'b0;
    end
    else
    begin
      cmp_irq <= |(irq_stat_r & irq_en_r)
        || (compare_event_flag_r && interrupt_enable_register_r[`CMPIRQ_IE_CMP_BIT]);
      cmp_wake <= idle_mode && idle_run_bit_r && compare_event_flag_r
        && interrupt_enable_register_r[`CMPIRQ_IE_CMP_BIT] && !power_down;
      cmp_level <= evt.sample;
    end
  end

  assign ctrl_view = {2'h0, idle_run_bit_r, compare_event_flag_r, comparator_enable_bit_r,
    event_condition_select_r};

  // Read channel: one read in flight, answered one cycle after address accepted
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        if (addr_is(s_axi_araddr, `CMPIRQ_CTRL_ADDR))
          s_axi_rdata <= {24'h000000, ctrl_view};
        else if (addr_is(s_axi_araddr, `CMPIRQ_IRQ_STAT_ADDR))
          s_axi_rdata <= {30'h0, irq_stat_r};
        else if (addr_is(s_axi_araddr, `CMPIRQ_IRQ_EN_ADDR))
          s_axi_rdata <= {30'h0, irq_en_r};
        else if (addr_is(s_axi_araddr, `CMPIRQ_PWR_ADDR))
          s_axi_rdata <= {24'h000000, interrupt_enable_register_r};
        else if (addr_is(s_axi_araddr, `CMPIRQ_RAW_ADDR))
          s_axi_rdata <= {31'h0, evt.sample};
        else
          s_axi_rdata <= 32'h0000_0000;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [bench/cmpirq_partner.sv]
// Model of the comparator output and the free-running timer one
`timescale 1ns/100ps
`default_nettype none
module cmpirq_partner (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Commanded level and timer period
  input wire logic lvl,
  input wire logic [7:0] period,
  // Towards the block
  output logic cmp_out,
  output logic timer1_ovf
);
  logic [7:0] cnt_r;
  assign cmp_out = lvl;
  // Free running: first overflow after an edge may come at once
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cnt_r <= 8'h0;
      timer1_ovf <= 1'h0;
    end
    else
    begin
      cnt_r <= (cnt_r == period - 8'h1) ? 8'h0 : cnt_r + 8'h1;
      timer1_ovf <= (cnt_r == period - 8'h1);
    end
  end
endmodule
`default_nettype wire

// [bench/cmpirq_monitor.sv]
// Port checker for the comparator event block
`timescale 1ns/100ps
`default_nettype none
module cmpirq_monitor (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Inputs
  input wire logic cmp_out,
  input wire logic idle_mode,
  input wire logic power_down,
  input wire logic s_axi_rready,
  // Outputs
  input wire logic s_axi_awready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic cmp_irq,
  input wire logic cmp_wake,
  input wire logic cmp_level
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  pd_quiet_a: assert property (power_down |=> !cmp_level)
    else $error("level seen in power-down");
  pd_nowake_a: assert property (power_down |=> !cmp_wake)
    else $error("wake seen in power-down");
  level_src_a: assert property (cmp_level |-> $past(cmp_out))
    else $error("level high without comparator high");
  wake_cause_a: assert property (cmp_wake |-> $past(idle_mode))
    else $error("wake outside idle");
  wake_irq_a: assert property (cmp_wake |-> cmp_irq)
    else $error("wake without interrupt");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  read_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than a cycle");
endmodule
bind cmpirq_top cmpirq_monitor chk (.clock, .rst_n, .cmp_out, .idle_mode, .power_down,
  .s_axi_rready, .s_axi_awready, .s_axi_rvalid, .s_axi_rdata, .cmp_irq, .cmp_wake, .cmp_level);
`default_nettype wire

// [bench/comparator_irq_debounce_tb.sv]
// Self-checking bench of the comparator event block
`timescale 1ns/100ps
`default_nettype none
`include "cmpirq_regs.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module comparator_irq_debounce_tb;
  localparam int PER = 16;
  logic clock = 0, rst_n = 0, lvl = 0, idle = 0, pd = 0;
  logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd_d, d;
  logic [3:0] ws = 0;
  logic awr, wr_r, bv, arr, rv, irq, wake, lvo, co, ovf;
  logic [1:0] br, rr, r;
  logic [31:0] seed = 32'he84e;
  int n_mismatch = 0, n_checks = 0, cyc = 0, n, m, k, i;
  logic s;
  always #25 clock = ~clock;
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_mismatch++;
      close_out();
    end
  end
  cmpirq_partner far (.clock(clock), .rst_n(rst_n), .lvl(lvl), .period(8'(PER)),
    .cmp_out(co), .timer1_ovf(ovf));
  cmpirq_top uut (.clock(clock), .rst_n(rst_n), .cmp_out(co), .timer1_ovf(ovf),
    .idle_mode(idle), .power_down(pd), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_d),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .cmp_irq(irq),
    .cmp_wake(wake), .cmp_level(lvo));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected flag for a level step from s to e under mode c
  function automatic logic ef(input int c, input logic s0, input logic e0);
    case (c)
      0: return !s0 || !e0;
      1, 3: return !s0 && e0;
      4, 6: return s0 && !e0;
      2, 5: return s0 != e0;
      default: return s0 || e0;
    endcase
  endfunction
  // Upper data bits are random noise the slave must ignore
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    logic [31:0] x;
    x = xs();
    @(posedge clock);
    awa <= a; awv <= 1'h1; wd <= {x[31:8], v}; ws <= 4'hf; wv <= 1'h1; bry <= 1'h1;
    while (1)
    begin
      @(posedge clock);
      if (awr) awv <= 1'h0;
      if (wr_r) wv <= 1'h0;
      if (bv) break;
    end
    r = br;
    bry <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clock);
    ara <= a; arv <= 1'h1; rry <= 1'h1;
    while (1)
    begin
      @(posedge clock);
      if (arr) arv <= 1'h0;
      if (rv) break;
    end
    d = rd_d;
    r = rr;
    rry <= 1'h0;
  endtask
  task automatic cy(input int c);
    repeat (c) @(posedge clock);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    cy(5);
    rst_n <= 1'h1;
    rd(`CMPIRQ_CTRL_ADDR); `CHK(d, 32'h0)
    rd(`CMPIRQ_IRQ_EN_ADDR); `CHK(d, 32'h0)
    rd(12'h3f0); `CHK(r, 2'h2)
    `CHK(d, 32'h0)
    wr(12'h3f0, 8'h00); `CHK(r, 2'h2)
    for (m = 0; m < 8; m++)
      for (k = 0; k < 2; k++)
      begin
        s = k[0];
        lvl <= s;
        wr(`CMPIRQ_CTRL_ADDR, 8'(8'h08 | m));
        cy(3 * PER);
        wr(`CMPIRQ_CTRL_ADDR, 8'(8'h08 | m));
        lvl <= !s;
        cy(3 * PER);
        rd(`CMPIRQ_CTRL_ADDR);
        `CHK(d, 32'(8'h08 | m | (ef(m, s, !s) << 4)))
      end
    lvl <= 1'h1;
    wr(`CMPIRQ_CTRL_ADDR, 8'h0f); `CHK(r, 2'h0)
    rd(`CMPIRQ_CTRL_ADDR); `CHK(d[4], 1'h1)
    lvl <= 1'h0;
    cy(3 * PER);
    wr(`CMPIRQ_CTRL_ADDR, 8'h0b);
    lvl <= 1'h1;
    cy(1 + int'(xs() % 4));
    lvl <= 1'h0;
    cy(3 * PER);
    rd(`CMPIRQ_CTRL_ADDR); `CHK(d[4], 1'h0)
    wr(`CMPIRQ_IRQ_CLR_ADDR, 8'h03);
    rd(`CMPIRQ_IRQ_STAT_ADDR); `CHK(d, 32'h0)
    wr(`CMPIRQ_IRQ_EN_ADDR, 8'h01);
    lvl <= 1'h1;
    for (n = 0; n < 4 * PER && !irq; n++) @(posedge clock);
    `CHK(n >= PER && n <= 2 * PER + 6, 1'h1)
    rd(`CMPIRQ_IRQ_STAT_ADDR); `CHK(d[0], 1'h1)
    wr(`CMPIRQ_IRQ_EN_ADDR, 8'h00);
    cy(3); `CHK(irq, 1'h0)
    wr(`CMPIRQ_PWR_ADDR, 8'h40);
    cy(3); `CHK(irq, 1'h1)
    wr(`CMPIRQ_IRQ_CLR_ADDR, 8'h01);
    wr(`CMPIRQ_CTRL_ADDR, 8'h0b);
    rd(`CMPIRQ_IRQ_STAT_ADDR); `CHK(d[0], 1'h0)
    `CHK(irq, 1'h0)
    lvl <= 1'h0;
    wr(`CMPIRQ_CTRL_ADDR, 8'h01);
    lvl <= 1'h1;
    cy(5);
    rd(`CMPIRQ_RAW_ADDR); `CHK(d, 32'h0)
    `CHK(lvo, 1'h0)
    rd(`CMPIRQ_CTRL_ADDR); `CHK(d[4], 1'h0)
    wr(`CMPIRQ_CTRL_ADDR, 8'h09);
    cy(3);
    rd(`CMPIRQ_RAW_ADDR); `CHK(d, 32'h1)
    `CHK(lvo, 1'h1)
    for (i = 0; i < 3; i++)
    begin
      lvl <= 1'h0;
      wr(`CMPIRQ_CTRL_ADDR, 8'(8'h09 | ((i > 0) << 5)));
      idle <= 1'h1;
      pd <= (i == 2);
      cy(3);
      lvl <= 1'h1;
      cy(4);
      `CHK(wake, (i == 1))
      rd(`CMPIRQ_CTRL_ADDR); `CHK(d[4], (i == 1))
      idle <= 1'h0;
      pd <= 1'h0;
    end
    rd(`CMPIRQ_IRQ_STAT_ADDR); `CHK(d[1], 1'h1)
    close_out();
  end
endmodule
`default_nettype wire
